// file: hdl/gdr_defines.vh
// Function
// - Summary bit 7 ORs others except warning
// - Bits 6,5,1,0: watchdog, gate, overtemp
// - Summary bit 4 flags any overcurrent
// - Bit 3 supply, bit 2 pump undervoltage
// - Per-FET gate faults in bits 7..4
// - Per-FET overcurrent faults in bits 3..0
// - Status registers read-only, reset to zero
// - Control registers 0x02..0x05 read/write
// - Writing 110b locks; lock blocks writes to 0x03..0x05
// - Writing 011b unlocks; default unlocked
// - Bit 2 ORed with bridge input one
// - Bit 1 ORed with bridge input two
// - Writing one to bit 0 clears faults
// - 16-bit MSB-first frame, reply low byte
// - Settings reset on undervoltage recovery, wake
`ifndef GDR_DEFINES_VH
`define GDR_DEFINES_VH
`define GDR_ADDR_FAULT   4'h0
`define GDR_ADDR_FET     4'h1
`define GDR_ADDR_MAIN    4'h2
`define GDR_ADDR_DRIVE   4'h3
`define GDR_ADDR_MON     4'h4
`define GDR_ADDR_CFG     4'h5
`define GDR_BIT_ANY      7
`define GDR_BIT_WDOG     6
`define GDR_BIT_GATE     5
`define GDR_BIT_OCUR     4
`define GDR_BIT_SUPUV    3
`define GDR_BIT_PMPUV    2
`define GDR_BIT_OVERTEMP_SHUTDOWN_FLAG     1
`define GDR_BIT_OTW      0
`define GDR_LOCK_HI      5
`define GDR_LOCK_LO      3
`define GDR_LOCK_SET     3'h6
`define GDR_LOCK_CLR     3'h3
`define GDR_BIT_IN1      2
`define GDR_BIT_IN2      1
`define GDR_BIT_CLR      0
`define GDR_RST_MAIN     8'h18
`define GDR_RST_DRIVE    8'h07
`define GDR_RST_MON      8'h70
`define GDR_RST_CFG      8'h01
`define GDR_FRAME_BITS   16
`define GDR_FB_RW        15
`define GDR_FB_AHI       14
`define GDR_FB_ALO       11
`endif

// file: hdl/gdr_spi_slave.v
`timescale 1ns/10ps
`include "gdr_defines.vh"
// SPI mode 1 slave, fully sampled on clk. Outputs one pulse per full frame.
module gdr_spi_slave (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        sclkPin,
  input  wire        csPin_b,
  input  wire        sdiPin,
  output reg         sdoOut,
  output wire        sdoOe_b,
  output reg         frameDone,
  output reg         frameRead,
  output reg  [3:0]  frameAddr,
  output reg  [7:0]  frameData,
  output reg         addrValid,
  output reg  [3:0]  peekAddr,
  input  wire [7:0]  peekData
);
  reg  [2:0]  sclkSync_r;
  reg  [2:0]  csSync_r;
  reg  [2:0]  sdiSync_r;
  reg         sclkLvl_r;
  reg         csLvl_r;
  reg  [15:0] shiftIn_r;
  reg  [7:0]  shiftOut_r;
  reg  [4:0]  bitCnt_r;
  wire        sclkRise;
  wire        sclkFall;
  wire        csFall;
  wire        csRise;

  // Change accepted once stages two and three agree
  assign sclkRise = (sclkSync_r[1] == sclkSync_r[2]) & sclkSync_r[2]
                    & ~sclkLvl_r;
  assign sclkFall = (sclkSync_r[1] == sclkSync_r[2]) & ~sclkSync_r[2]
                    & sclkLvl_r;
  assign csFall   = (csSync_r[1] == csSync_r[2]) & ~csSync_r[2] & csLvl_r;
  assign csRise   = (csSync_r[1] == csSync_r[2]) & csSync_r[2] & ~csLvl_r;
  assign sdoOe_b  = csLvl_r;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclkSync_r <= 3'h0;
      csSync_r   <= 3'h7;
      sdiSync_r  <= 3'h0;
      sclkLvl_r  <= 1'b0;
      csLvl_r    <= 1'b1;
      shiftIn_r  <= 16'h0000;
      shiftOut_r <= 8'h00;
      bitCnt_r   <= 5'h00;
      sdoOut     <= 1'b0;
      frameDone  <= 1'b0;
      frameRead  <= 1'b0;
      frameAddr  <= 4'h0;
      frameData  <= 8'h00;
      addrValid  <= 1'b0;
      peekAddr   <= 4'h0;
    end else begin
      sclkSync_r <= {sclkSync_r[1:0], sclkPin};
      csSync_r   <= {csSync_r[1:0], csPin_b};
      sdiSync_r  <= {sdiSync_r[1:0], sdiPin};
      frameDone  <= 1'b0;
      if (sclkSync_r[1] == sclkSync_r[2])
        sclkLvl_r <= sclkSync_r[2];
      if (csSync_r[1] == csSync_r[2])
        csLvl_r <= csSync_r[2];
      if (csFall) begin
        bitCnt_r <= 5'h00;
        sdoOut   <= 1'b0;
      end else if (!csLvl_r) begin
        // Sample on falling edge, MSB first
        if (sclkFall) begin
          shiftIn_r <= {shiftIn_r[14:0], sdiSync_r[2]};
          if (bitCnt_r != 5'h1F)
            bitCnt_r <= bitCnt_r + 5'h01;
          if (bitCnt_r == 5'h04) begin
            peekAddr <= {shiftIn_r[2:0], sdiSync_r[2]};
          end
          if (bitCnt_r == 5'h07)
            shiftOut_r <= peekData;
        end
        // Drive on rising edge; reply byte goes in bits 7..0
        if (sclkRise) begin
          if (bitCnt_r >= 5'h08 && bitCnt_r < 5'h10) begin
            sdoOut     <= shiftOut_r[7];
            shiftOut_r <= {shiftOut_r[6:0], 1'b0};
          end else begin
            sdoOut <= 1'b0;
          end
        end
      end
      // Frames other than exactly 16 bits are dropped
      if (csRise && bitCnt_r == `GDR_FRAME_BITS) begin
        frameDone <= 1'b1;
        frameRead <= shiftIn_r[`GDR_FB_RW];
        frameAddr <= shiftIn_r[`GDR_FB_AHI:`GDR_FB_ALO];
        frameData <= shiftIn_r[7:0];
        addrValid <= (shiftIn_r[`GDR_FB_AHI:`GDR_FB_ALO] <= `GDR_ADDR_CFG);
      end
    end
  end
endmodule // gdr_spi_slave

// file: hdl/gdr_fault_regs.v
`timescale 1ns/10ps
`include "gdr_defines.vh"
module gdr_fault_regs (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        wakeEvent,
  input  wire        sclkPin,
  input  wire        csPin_b,
  input  wire        sdiPin,
  output wire        sdoOut,
  output wire        sdoOe_b,
  input  wire        watchdogTimeout,
  input  wire        pumpUndervoltage,
  input  wire        overtempShutdown,
  input  wire        overtempWarning,
  input  wire        supplyUndervoltage,
  input  wire [3:0]  fetGateFault,
  input  wire [3:0]  fetOvercurrent,
  input  wire        bridgeInOnePin,
  input  wire        bridgeInTwoPin,
  output reg         bridgeInputOne,
  output reg         bridgeInputTwo,
  output wire        settingsLocked,
  output reg  [7:0]  driveCtrl,
  output reg  [7:0]  monitorCtrl,
  output reg  [7:0]  chopCfg,
  output wire [7:0]  faultSummary,
  output wire [7:0]  fetStatus
);
  reg  [2:0]  evSync_r [0:10];
  reg  [10:0] evLvl_r;
  wire [10:0] evRaw;
  reg  [6:0]  sumFlag_r;
  reg  [7:0]  fetFlag_r;
  reg  [7:0]  mainCtrl_r;
  reg         uvPrev_r;
  wire        frameDone;
  wire        frameRead;
  wire [3:0]  frameAddr;
  wire [7:0]  frameData;
  wire        addrValid;
  wire [3:0]  peekAddr;
  reg  [7:0]  peekData;
  wire        doWrite;
  wire        doClear;
  wire        settingsReset;
  wire [2:0]  lockNew;
  wire        uvNow;
  genvar      g;

  assign evRaw = {supplyUndervoltage, fetOvercurrent, fetGateFault,
                  watchdogTimeout, pumpUndervoltage};

  // Async fault inputs: three stages, accepted once two agree
  generate
    for (g = 0; g < 11; g = g + 1) begin : gSync
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          evSync_r[g] <= 3'h0;
          evLvl_r[g]  <= 1'b0;
        end else begin
          evSync_r[g] <= {evSync_r[g][1:0], evRaw[g]};
          if (evSync_r[g][1] == evSync_r[g][2])
            evLvl_r[g] <= evSync_r[g][2];
        end
      end
    end
  endgenerate

  reg [2:0] otSync_r;
  reg [2:0] owSync_r;
  reg [2:0] in1Sync_r;
  reg [2:0] in2Sync_r;
  reg       otLvl_r;
  reg       owLvl_r;
  reg       in1Lvl_r;
  reg       in2Lvl_r;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      otSync_r  <= 3'h0;
      owSync_r  <= 3'h0;
      in1Sync_r <= 3'h0;
      in2Sync_r <= 3'h0;
      otLvl_r   <= 1'b0;
      owLvl_r   <= 1'b0;
      in1Lvl_r  <= 1'b0;
      in2Lvl_r  <= 1'b0;
    end else begin
      otSync_r  <= {otSync_r[1:0], overtempShutdown};
      owSync_r  <= {owSync_r[1:0], overtempWarning};
      in1Sync_r <= {in1Sync_r[1:0], bridgeInOnePin};
      in2Sync_r <= {in2Sync_r[1:0], bridgeInTwoPin};
      if (otSync_r[1] == otSync_r[2])
        otLvl_r <= otSync_r[2];
      if (owSync_r[1] == owSync_r[2])
        owLvl_r <= owSync_r[2];
      if (in1Sync_r[1] == in1Sync_r[2])
        in1Lvl_r <= in1Sync_r[2];
      if (in2Sync_r[1] == in2Sync_r[2])
        in2Lvl_r <= in2Sync_r[2];
    end
  end

  gdr_spi_slave uSpi (
    .clk       (clk),
    .rst_b     (rst_b),
    .sclkPin   (sclkPin),
    .csPin_b   (csPin_b),
    .sdiPin    (sdiPin),
    .sdoOut    (sdoOut),
    .sdoOe_b   (sdoOe_b),
    .frameDone (frameDone),
    .frameRead (frameRead),
    .frameAddr (frameAddr),
    .frameData (frameData),
    .addrValid (addrValid),
    .peekAddr  (peekAddr),
    .peekData  (peekData)
  );

  assign uvNow = evLvl_r[10];
  // Settings return to defaults on undervoltage recovery or wake
  assign settingsReset = (uvPrev_r & ~uvNow) | wakeEvent;
  assign settingsLocked = (mainCtrl_r[`GDR_LOCK_HI:`GDR_LOCK_LO]
                           == `GDR_LOCK_SET);
  // Only writes change state; reads have no side effect
  assign doWrite = frameDone & ~frameRead & addrValid;
  assign doClear = doWrite & (frameAddr == `GDR_ADDR_MAIN)
                   & frameData[`GDR_BIT_CLR];
  assign lockNew = frameData[`GDR_LOCK_HI:`GDR_LOCK_LO];

  // Read mux for the reply byte; unmapped addresses answer zero
  always @* begin
    case (peekAddr)
      `GDR_ADDR_FAULT: peekData = faultSummary;
      `GDR_ADDR_FET:   peekData = fetStatus;
      `GDR_ADDR_MAIN:  peekData = mainCtrl_r;
      `GDR_ADDR_DRIVE: peekData = driveCtrl;
      `GDR_ADDR_MON:   peekData = monitorCtrl;
      `GDR_ADDR_CFG:   peekData = chopCfg;
      default:         peekData = 8'h00;
    endcase
  end

  // Summary bits map: 6 wdog, 5 gate, 4 ocur, 3 sup, 2 pump, 1 overtemp_shutdown_flag, 0 otw
  assign faultSummary = {(|sumFlag_r[6:1]), sumFlag_r};
  assign fetStatus    = fetFlag_r;

  // Sticky flags, set wins over clear; registers are read-only
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sumFlag_r <= 7'h00;
      fetFlag_r <= 8'h00;
      uvPrev_r  <= 1'b0;
    end else begin
      uvPrev_r <= uvNow;
      if (doClear) begin
        sumFlag_r <= 7'h00;
        fetFlag_r <= 8'h00;
      end
      if (evLvl_r[1])
        sumFlag_r[`GDR_BIT_WDOG]  <= 1'b1;
      // Same-cycle clear drops old flags, new events still win
      if (|evLvl_r[5:2]) begin
        sumFlag_r[`GDR_BIT_GATE]  <= 1'b1;
        fetFlag_r[7:4] <= (fetFlag_r[7:4] & {4{~doClear}})
                          | evLvl_r[5:2];
      end
      if (|evLvl_r[9:6]) begin
        sumFlag_r[`GDR_BIT_OCUR]  <= 1'b1;
        fetFlag_r[3:0] <= (fetFlag_r[3:0] & {4{~doClear}})
                          | evLvl_r[9:6];
      end
      if (uvNow)
        sumFlag_r[`GDR_BIT_SUPUV] <= 1'b1;
      if (evLvl_r[0])
        sumFlag_r[`GDR_BIT_PMPUV] <= 1'b1;
      if (otLvl_r)
        sumFlag_r[`GDR_BIT_OVERTEMP_SHUTDOWN_FLAG]  <= 1'b1;
      if (owLvl_r)
        sumFlag_r[`GDR_BIT_OTW]   <= 1'b1;
    end
  end

  // Control registers, lock handling
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mainCtrl_r  <= `GDR_RST_MAIN;
      driveCtrl   <= `GDR_RST_DRIVE;
      monitorCtrl <= `GDR_RST_MON;
      chopCfg     <= `GDR_RST_CFG;
    end else if (settingsReset) begin
      mainCtrl_r  <= `GDR_RST_MAIN;
      driveCtrl   <= `GDR_RST_DRIVE;
      monitorCtrl <= `GDR_RST_MON;
      chopCfg     <= `GDR_RST_CFG;
    end else begin
      if (doWrite) begin
        case (frameAddr)
          `GDR_ADDR_MAIN: begin
            mainCtrl_r[7:6] <= frameData[7:6];
            mainCtrl_r[`GDR_BIT_IN1] <= frameData[`GDR_BIT_IN1];
            mainCtrl_r[`GDR_BIT_IN2] <= frameData[`GDR_BIT_IN2];
            if (!settingsLocked && lockNew == `GDR_LOCK_SET)
              mainCtrl_r[`GDR_LOCK_HI:`GDR_LOCK_LO] <= lockNew;
            if (settingsLocked && lockNew == `GDR_LOCK_CLR)
              mainCtrl_r[`GDR_LOCK_HI:`GDR_LOCK_LO] <= lockNew;
          end
          `GDR_ADDR_DRIVE: begin
            if (!settingsLocked)
              driveCtrl <= frameData;
          end
          `GDR_ADDR_MON: begin
            if (!settingsLocked)
              monitorCtrl <= frameData;
          end
          `GDR_ADDR_CFG: begin
            if (!settingsLocked)
              chopCfg <= frameData;
          end
          default: begin
          end
        endcase
      end
      // Clear command never stays set
      mainCtrl_r[`GDR_BIT_CLR] <= 1'b0;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bridgeInputOne <= 1'b0;
      bridgeInputTwo <= 1'b0;
    end else begin
      bridgeInputOne <= in1Lvl_r | mainCtrl_r[`GDR_BIT_IN1];
      bridgeInputTwo <= in2Lvl_r | mainCtrl_r[`GDR_BIT_IN2];
    end
  end
endmodule // gdr_fault_regs

// file: tb/gdr_fault_regs_chk.sv
`timescale 1ns/10ps
module gdr_fault_regs_chk (
  input wire       clk,
  input wire       rst_b,
  input wire       csPin_b,
  input wire       sdoOe_b,
  input wire       watchdogTimeout,
  input wire [3:0] fetGateFault,
  input wire [3:0] fetOvercurrent,
  input wire       bridgeInOnePin,
  input wire       bridgeInTwoPin,
  input wire       bridgeInputOne,
  input wire       bridgeInputTwo,
  input wire [7:0] faultSummary,
  input wire [7:0] fetStatus
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_summary_or: assert property (
    faultSummary[7] == |faultSummary[6:1]) else $error("summary bit off");
  chk_ocur_any: assert property (
    |fetStatus[3:0] |-> faultSummary[4]) else $error("overcurrent sum");
  chk_gate_any: assert property (
    |fetStatus[7:4] |-> faultSummary[5]) else $error("gate fault sum");
  // Pin passes a 3-stage sync plus level and output registers
  chk_bridge_one: assert property (
    bridgeInOnePin [*6] |-> bridgeInputOne) else $error("input one low");
  chk_bridge_two: assert property (
    bridgeInTwoPin [*6] |-> bridgeInputTwo) else $error("input two low");
  // Chip select low keeps any clear far away
  chk_wdog_flag: assert property (
    (watchdogTimeout && !csPin_b) [*6] |-> faultSummary[6])
    else $error("watchdog flag missing");
  chk_gate_flag: assert property (
    (fetGateFault[3] && !csPin_b) [*6] |-> fetStatus[7])
    else $error("gate flag missing");
  chk_ocur_flag: assert property (
    (fetOvercurrent[0] && !csPin_b) [*6] |-> fetStatus[0])
    else $error("overcurrent flag missing");
  chk_flag_hold: assert property (
    $fell(|faultSummary[6:0]) |-> csPin_b) else $error("flag lost");
  chk_sdo_release: assert property (
    csPin_b [*5] |-> sdoOe_b) else $error("data out driven");
  cover property ($fell(faultSummary[7]));
  cover property (bridgeInputOne && !bridgeInOnePin);
  cover property ($rose(fetStatus[0]));
endmodule // gdr_fault_regs_chk

bind gdr_fault_regs gdr_fault_regs_chk u_gdr_fault_regs_chk (
  .clk(clk), .rst_b(rst_b), .csPin_b(csPin_b), .sdoOe_b(sdoOe_b),
  .watchdogTimeout(watchdogTimeout), .fetGateFault(fetGateFault),
  .fetOvercurrent(fetOvercurrent), .bridgeInOnePin(bridgeInOnePin),
  .bridgeInTwoPin(bridgeInTwoPin), .bridgeInputOne(bridgeInputOne),
  .bridgeInputTwo(bridgeInputTwo), .faultSummary(faultSummary),
  .fetStatus(fetStatus));

// file: tb/gdr_spi_host.sv
`timescale 1ns/10ps
module gdr_spi_host (
  input  wire clk,
  input  wire sdoOut,
  output reg  sclkPin,
  output reg  csPin_b,
  output reg  sdiPin
);
  initial begin
    sclkPin = 1'b0;
    csPin_b = 1'b1;
    sdiPin = 1'b0;
  end
  // Slow half period so the synchronised pins see every edge
  task automatic half;
    repeat (8) @(posedge clk);
    #1;
  endtask
  // nb below 16 sends a cut frame, which the device must drop
  task automatic xfer(input logic [15:0] f, input int nb,
                      output logic [7:0] r);
    r = 8'h00;
    csPin_b = 1'b0;
    for (int i = 15; i >= 16 - nb; i--) begin
      half;
      sclkPin = 1'b1;
      // Launch with the rise so the bit is steady over the capturing fall
      sdiPin = f[i];
      half;
      if (i < 8) r[i] = sdoOut;
      sclkPin = 1'b0;
    end
    half;
    csPin_b = 1'b1;
    // Released line must not look like the last bit
    sdiPin = ~sdiPin;
    repeat (120) @(posedge clk);
    #1;
  endtask
endmodule // gdr_spi_host

// file: tb/gdr_fault_regs_test.sv
`timescale 1ns/10ps
module gdr_fault_regs_test;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       wakeEvent = 1'b0;
  logic       watchdogTimeout = 1'b0;
  logic       pumpUndervoltage = 1'b0;
  logic       overtempShutdown = 1'b0;
  logic       overtempWarning = 1'b0;
  logic       supplyUndervoltage = 1'b0;
  logic [3:0] fetGateFault = 4'h0;
  logic [3:0] fetOvercurrent = 4'h0;
  logic       bridgeInOnePin = 1'b0;
  logic       bridgeInTwoPin = 1'b0;
  wire        sclkPin, csPin_b, sdiPin, sdoOut, sdoOe_b;
  wire        bridgeInputOne, bridgeInputTwo, settingsLocked;
  wire  [7:0] driveCtrl, monitorCtrl, chopCfg, faultSummary, fetStatus;
  int         mismatches = 0;
  int         comparisons = 0;
  int         cycles = 0;
  int         j;
  logic [7:0] r, d, e0, e1;
  logic [7:0] dflt [0:5] = '{8'h00, 8'h00, 8'h18, 8'h07, 8'h70, 8'h01};

  always #2.5 clk = ~clk;

  gdr_fault_regs u_gdr_fault_regs (
    .clk(clk), .rst_b(rst_b), .wakeEvent(wakeEvent), .sclkPin(sclkPin),
    .csPin_b(csPin_b), .sdiPin(sdiPin), .sdoOut(sdoOut), .sdoOe_b(sdoOe_b),
    .watchdogTimeout(watchdogTimeout), .pumpUndervoltage(pumpUndervoltage),
    .overtempShutdown(overtempShutdown), .overtempWarning(overtempWarning),
    .supplyUndervoltage(supplyUndervoltage), .fetGateFault(fetGateFault),
    .fetOvercurrent(fetOvercurrent), .bridgeInOnePin(bridgeInOnePin),
    .bridgeInTwoPin(bridgeInTwoPin), .bridgeInputOne(bridgeInputOne),
    .bridgeInputTwo(bridgeInputTwo), .settingsLocked(settingsLocked),
    .driveCtrl(driveCtrl), .monitorCtrl(monitorCtrl), .chopCfg(chopCfg),
    .faultSummary(faultSummary), .fetStatus(fetStatus));
  gdr_spi_host u_gdr_spi_host (.clk(clk), .sdoOut(sdoOut),
    .sclkPin(sclkPin), .csPin_b(csPin_b), .sdiPin(sdiPin));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    u_gdr_spi_host.xfer({1'b1, a, 3'h0, 8'h00}, 16, v);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v,
                    output logic [7:0] o);
    u_gdr_spi_host.xfer({1'b0, a, 3'h0, v}, 16, o);
  endtask
  function automatic logic [7:0] sumExp(input logic [6:0] f);
    sumExp = {|f[6:1], f};
  endfunction

  always @(posedge clk) begin
    cycles++;
    if (cycles == 50000) begin
      mismatches++;
      report_and_stop;
    end
  end

  initial begin
    void'($urandom(32'h9E45));
    repeat (8) @(posedge clk);
    #1 rst_b = 1'b1;
    for (int a = 0; a < 6; a++) begin
      rd(a[3:0], r);
      check(r, dflt[a]);
    end
    rd(4'h9, r);
    check(r, 8'h00);
    for (int a = 0; a < 6; a++) begin
      if (a == 2) continue;
      d = $urandom;
      wr(a[3:0], d, r);
      check(r, dflt[a]);
      rd(a[3:0], r);
      check(r, (a < 2) ? 8'h00 : d);
    end
    $display("register test done");
    wr(4'h2, 8'h30, r);
    check({7'h00, settingsLocked}, 8'h01);
    wr(4'h5, ~d, r);
    rd(4'h5, r);
    check(r, d);
    check(chopCfg, d);
    wr(4'h2, 8'h28, r);
    check({7'h00, settingsLocked}, 8'h01);
    wr(4'h2, 8'h18, r);
    check({7'h00, settingsLocked}, 8'h00);
    wr(4'h2, 8'h08, r);
    rd(4'h2, r);
    check(r, 8'h18);
    $display("lock test done");
    for (int n = 0; n < 4; n++) begin
      d = $urandom;
      bridgeInOnePin = d[1];
      bridgeInTwoPin = d[0];
      wr(4'h2, {5'h03, n[1:0], 1'b0}, r);
      rd(4'h2, r);
      check(r, {5'h03, n[1:0], 1'b0});
      e0 = {6'h00, n[1:0] | d[1:0]};
      check({6'h00, bridgeInputOne, bridgeInputTwo}, e0);
    end
    wr(4'h2, 8'h18, r);
    $display("bridge test done");
    for (int k = 0; k < 7; k++) begin
      j = $urandom % 4;
      case (k)
        6: watchdogTimeout = 1'b1;
        5: fetGateFault[j] = 1'b1;
        4: fetOvercurrent[j] = 1'b1;
        3: supplyUndervoltage = 1'b1;
        2: pumpUndervoltage = 1'b1;
        1: overtempShutdown = 1'b1;
        default: overtempWarning = 1'b1;
      endcase
      e0 = sumExp(7'h01 << k);
      e1 = (k == 5) ? (8'h10 << j) : (k == 4) ? (8'h01 << j) : 8'h00;
      rd(4'h0, r);
      check(r, e0);
      check(faultSummary, e0);
      rd(4'h1, r);
      check(r, e1);
      {watchdogTimeout, pumpUndervoltage, overtempShutdown} = 3'h0;
      {overtempWarning, supplyUndervoltage} = 2'h0;
      {fetGateFault, fetOvercurrent} = 8'h00;
      rd(4'h0, r);
      check(r, e0);
      wr(4'h2, 8'h19, r);
      check(r, 8'h18);
      rd(4'h0, r);
      check(r, 8'h00);
      rd(4'h1, r);
      check(r, 8'h00);
      rd(4'h2, r);
      check(r, 8'h18);
    end
    fetGateFault = 4'hF;
    fetOvercurrent = 4'hF;
    rd(4'h1, r);
    check(r, 8'hFF);
    check(fetStatus, 8'hFF);
    check(faultSummary, sumExp(7'h30));
    {fetGateFault, fetOvercurrent} = 8'h00;
    wr(4'h2, 8'h19, r);
    check(fetStatus, 8'h00);
    $display("fault test done");
    wr(4'h3, 8'hA5, r);
    @(posedge clk);
    #1 wakeEvent = 1'b1;
    @(posedge clk);
    #1 wakeEvent = 1'b0;
    rd(4'h3, r);
    check(r, 8'h07);
    check(driveCtrl, 8'h07);
    u_gdr_spi_host.xfer({1'b0, 4'h3, 3'h0, 8'h5A}, 15, r);
    rd(4'h3, r);
    check(r, 8'h07);
    wr(4'h4, 8'h0F, r);
    supplyUndervoltage = 1'b1;
    repeat (10) @(posedge clk);
    #1 supplyUndervoltage = 1'b0;
    rd(4'h4, r);
    check(r, 8'h70);
    check(monitorCtrl, 8'h70);
    $display("reset event test done");
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    check(faultSummary, 8'h00);
    check(chopCfg, 8'h01);
    rd(4'h5, r);
    check(r, 8'h01);
    $display("mid reset test done");
    report_and_stop;
  end
endmodule // gdr_fault_regs_test
